// >>> rtl/usb_pkg.sv
// Package for the UART buffer alias and test-access block.
// Assumes one clock (core_clk, 40 MHz) and the UART reset (rst).
package usb_pkg;
	// Register byte offsets
	localparam logic [7:0] ALIAS_LO_OFS   = 8'h30;
	localparam logic [7:0] ALIAS_HI_OFS   = 8'h6c;
	localparam logic [7:0] TEST_EN_OFS    = 8'h70;
	localparam logic [7:0] TX_PEEK_OFS    = 8'h74;
	localparam logic [7:0] RX_INJECT_OFS  = 8'h78;
	// Field positions
	localparam int TEST_EN_BIT   = 0;
	localparam int INJ_PE_BIT    = 8;
	localparam int INJ_FE_BIT    = 9;
	// Reset values
	localparam logic       TEST_EN_RST = 1'b0;
	localparam logic [7:0] DATA_RST    = 8'h00;
	// FIFO shape (fixed)
	localparam int FIFO_DEPTH = 4;
	localparam int RX_WIDTH   = 10;
	localparam int TX_WIDTH   = 8;
endpackage

// >>> rtl/usb_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes push and pop come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module usb_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input  wire logic             core_clk,
	input  wire logic             rst,
	// Fill side
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	// Drain side
	output logic                  out_valid,
	output logic [WIDTH-1:0]      out_data,
	input  wire logic             out_ready,
	// Occupancy
	output logic [$clog2(DEPTH):0] level
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               rd;
		logic [AW-1:0]               wr;
		logic [AW:0]                 cnt;
	} usb_fifo_st_t;
	usb_fifo_st_t st;
	usb_fifo_st_t next_st;
	logic push;
	logic pop;

	////////////////////////////////////////////////////////////////////////
	// Handshake and flags
	assign in_ready  = (st.cnt != (AW+1)'(DEPTH));
	assign out_valid = (st.cnt != '0);
	assign out_data  = st.mem[st.rd];
	assign level     = st.cnt;
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	// Next state
	always_comb begin
		next_st = st;
		if (push) begin
			next_st.mem[st.wr] = in_data;
			next_st.wr = (st.wr == AW'(DEPTH-1)) ? '0 : st.wr + AW'(1);
		end
		if (pop) begin
			next_st.rd = (st.rd == AW'(DEPTH-1)) ? '0 : st.rd + AW'(1);
		end
		next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end

	// State register
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
endmodule
`default_nettype wire

// >>> rtl/usb_top.sv
// UART receive/transmit buffer aliases, overrun handling and FIFO test access.
// Assumes a simple register port on core_clk; receiver, transmitter and FIFO
// control live elsewhere and meet this block through plain signals.
`timescale 1ns/1ps
`default_nettype none
module usb_top
	import usb_pkg::*;
(
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst,
	// Register port
	input  wire logic        reg_sel,
	input  wire logic        reg_write,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	output logic [31:0]      reg_rdata,
	// Configuration from the FIFO control register
	input  wire logic        fifo_enable,
	// Receiver side
	input  wire logic        rx_char_valid,
	input  wire logic [7:0]  rx_char,
	input  wire logic        rx_framing_err,
	input  wire logic        rx_parity_err,
	// Transmitter side
	output logic             tx_char_valid,
	output logic [7:0]       tx_char,
	input  wire logic        tx_char_ready,
	// Status toward the line status register
	output logic             char_available_flag,
	output logic             overrun_pulse,
	output logic             rx_head_framing_err,
	output logic             rx_head_parity_err,
	output logic             test_access_mode
);
	typedef struct packed {
		logic [31:0] rdata;
		logic        test_en;
		logic [9:0]  rbr;
		logic        rbr_full;
		logic [7:0]  thr;
		logic        thr_full;
		logic        ovr;
		logic        tx_valid;
		logic [7:0]  tx_data;
		logic        avail;
		logic        fe;
		logic        pe;
	} usb_st_t;
	usb_st_t st;
	usb_st_t next_st;

	// Receive FIFO ports
	logic        rxf_in_valid;
	logic [9:0]  rxf_in_data;
	logic        rxf_in_ready;
	logic        rxf_out_valid;
	logic [9:0]  rxf_out_data;
	logic        rxf_out_ready;
	logic [2:0]  rxf_level;
	// Transmit FIFO ports
	logic        txf_in_valid;
	logic        txf_in_ready;
	logic        txf_out_valid;
	logic [7:0]  txf_out_data;
	logic        txf_out_ready;
	logic [2:0]  txf_level;

	// Decoded accesses
	logic alias_hit;
	logic alias_rd;
	logic alias_wr;
	logic peek_rd;
	logic inject_wr;
	logic test_wr;
	logic hw_rx;
	logic inj_push;

	////////////////////////////////////////////////////////////////////////
	// Address decoding helper
	function automatic logic in_alias(input logic [7:0] a);
		in_alias = (a >= ALIAS_LO_OFS) && (a <= ALIAS_HI_OFS) && (a[1:0] == 2'b00);
	endfunction

	// Access strobes
	always_comb begin
		alias_hit = in_alias(reg_addr);
		alias_rd  = reg_sel & ~reg_write & alias_hit;
		alias_wr  = reg_sel & reg_write & alias_hit;
		peek_rd   = 1'b0;
		inject_wr = 1'b0;
		test_wr   = 1'b0;
		if (reg_sel && reg_addr == TX_PEEK_OFS) begin
			peek_rd = ~reg_write & st.test_en;
		end else if (reg_sel && reg_addr == RX_INJECT_OFS) begin
			inject_wr = reg_write & st.test_en;
		end else if (reg_sel && reg_addr == TEST_EN_OFS) begin
			test_wr = reg_write;
		end
	end

	// In test mode the host replaces the receiver as the source
	assign hw_rx    = rx_char_valid & ~st.test_en;
	assign inj_push = inject_wr & fifo_enable;

	// Receive FIFO feed and drain
	// Without FIFOs the receiver feeds only the single buffer
	assign rxf_in_valid  = (hw_rx & fifo_enable) | inj_push;
	assign rxf_in_data   = inj_push ?
		{reg_wdata[INJ_FE_BIT], reg_wdata[INJ_PE_BIT], reg_wdata[7:0]} :
		{rx_framing_err, rx_parity_err, rx_char};
	assign rxf_out_ready = alias_rd & fifo_enable;

	// Transmit FIFO feed and drain
	assign txf_in_valid  = alias_wr & fifo_enable;
	assign txf_out_ready = st.test_en ? (peek_rd & fifo_enable)
	                                  : tx_char_ready;

	////////////////////////////////////////////////////////////////////////
	// Receive FIFO instance
	usb_fifo #(
		.WIDTH (RX_WIDTH),
		.DEPTH (FIFO_DEPTH)
	) u_rx_fifo (
		.core_clk  (core_clk),
		.rst       (rst),
		.in_valid  (rxf_in_valid),
		.in_data   (rxf_in_data),
		.in_ready  (rxf_in_ready),
		.out_valid (rxf_out_valid),
		.out_data  (rxf_out_data),
		.out_ready (rxf_out_ready),
		.level     (rxf_level)
	);

	// Transmit FIFO instance; its in_ready is not used, so alias writes to a full FIFO are lost
	usb_fifo #(
		.WIDTH (TX_WIDTH),
		.DEPTH (FIFO_DEPTH)
	) u_tx_fifo (
		.core_clk  (core_clk),
		.rst       (rst),
		.in_valid  (txf_in_valid),
		.in_data   (reg_wdata[7:0]),
		.in_ready  (txf_in_ready),
		.out_valid (txf_out_valid),
		.out_data  (txf_out_data),
		.out_ready (txf_out_ready),
		.level     (txf_level)
	);

	////////////////////////////////////////////////////////////////////////
	// Next-state logic
	always_comb begin
		next_st = st;
		next_st.ovr = 1'b0;
		// Test access enable register
		if (test_wr) begin
			next_st.test_en = reg_wdata[TEST_EN_BIT];
		end
		// Non-FIFO receive buffer: alias read empties it
		if (!fifo_enable && alias_rd) begin
			next_st.rbr_full = 1'b0;
		end
		if (!fifo_enable && (hw_rx || inject_wr)) begin
			next_st.rbr = inject_wr ?
				{reg_wdata[INJ_FE_BIT], reg_wdata[INJ_PE_BIT], reg_wdata[7:0]} :
				{rx_framing_err, rx_parity_err, rx_char};
			next_st.rbr_full = 1'b1;
			next_st.ovr = st.rbr_full & ~alias_rd;
		end
		// Full receive FIFO drops the new character
		if (fifo_enable && rxf_in_valid && !rxf_in_ready) begin
			next_st.ovr = 1'b1;
		end
		// Non-FIFO transmit holding register
		if (!fifo_enable && alias_wr) begin
			next_st.thr = reg_wdata[7:0];
			next_st.thr_full = 1'b1;
		end else if (!fifo_enable && st.thr_full) begin
			if (st.test_en ? peek_rd : (tx_char_ready && st.tx_valid)) begin
				next_st.thr_full = 1'b0;
			end
		end
		// Transmitter feed, held off in test mode
		if (fifo_enable) begin
			next_st.tx_valid = txf_out_valid & ~st.test_en;
			next_st.tx_data  = txf_out_data;
		end else begin
			next_st.tx_valid = next_st.thr_full & ~st.test_en;
			next_st.tx_data  = next_st.thr;
		end
		// Character-available flag and error flags of the head
		if (fifo_enable) begin
			next_st.avail = (rxf_level != 3'd0) | rxf_in_valid;
			if (rxf_level == 3'd1 && rxf_out_ready && !rxf_in_valid) begin
				next_st.avail = 1'b0;
			end
		end else begin
			next_st.avail = next_st.rbr_full;
		end
		// Read data: alias low byte, upper bits zero
		next_st.rdata = 32'h0000_0000;
		if (reg_sel && !reg_write) begin
			if (alias_hit) begin
				next_st.rdata[7:0] = fifo_enable ? rxf_out_data[7:0] : st.rbr[7:0];
			end else if (reg_addr == TEST_EN_OFS) begin
				next_st.rdata[TEST_EN_BIT] = st.test_en;
			end else if (reg_addr == TX_PEEK_OFS && st.test_en) begin
				next_st.rdata[7:0] = fifo_enable ? txf_out_data : st.thr;
			end
		end
		next_st.fe = fifo_enable ? rxf_out_data[9] : next_st.rbr[9];
		next_st.pe = fifo_enable ? rxf_out_data[8] : next_st.rbr[8];
	end

	// State register
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs straight from flip-flops
	assign reg_rdata           = st.rdata;
	assign tx_char_valid       = st.tx_valid;
	assign tx_char             = st.tx_data;
	assign char_available_flag = st.avail;
	assign overrun_pulse       = st.ovr;
	assign rx_head_framing_err = st.fe;
	assign rx_head_parity_err  = st.pe;
	assign test_access_mode    = st.test_en;
endmodule
`default_nettype wire

// >>> bench/usb_checker_asserts.sv
// Port checker for the buffer alias and test-access block.
// Assumes it is bound onto usb_top, one clock, reset active high.
`timescale 1ns/1ps
`default_nettype none
module usb_checker
	import usb_pkg::*;
(
	// Clock and reset
	input wire logic        core_clk,
	input wire logic        rst,
	// Register port
	input wire logic        reg_sel,
	input wire logic        reg_write,
	input wire logic [7:0]  reg_addr,
	input wire logic [31:0] reg_rdata,
	// Receive path and status
	input wire logic        fifo_enable,
	input wire logic        rx_char_valid,
	input wire logic        char_available_flag,
	input wire logic        overrun_pulse,
	input wire logic        test_access_mode
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////////////
	// Access and arrival steps
	sequence rd_s(a); reg_sel && !reg_write && reg_addr == a; endsequence
	sequence alias_rd_s;
		reg_sel && !reg_write && reg_addr >= ALIAS_LO_OFS && reg_addr <= ALIAS_HI_OFS;
	endsequence
	sequence rx_s; rx_char_valid && !test_access_mode; endsequence
	////////////////////////////////////////////////////////////////////////
	rd_quiet_a: assert property (!(reg_sel && !reg_write) |=> reg_rdata == 32'h0000_0000)
		else $error("read data not idle");
	upper_zero_a: assert property (alias_rd_s |=> reg_rdata[31:8] == 24'h00_0000)
		else $error("alias upper bits set");
	test_en_rd_a: assert property (rd_s(TEST_EN_OFS) |=> reg_rdata[0] == test_access_mode)
		else $error("test enable readback wrong");
	peek_off_a: assert property (rd_s(TX_PEEK_OFS) ##0 !test_access_mode |=> reg_rdata == 0)
		else $error("peek answered outside test mode");
	rx_avail_a: assert property (rx_s |=> char_available_flag)
		else $error("flag missing after arrival");
	ovr_cause_a: assert property (overrun_pulse |->
		$past(rx_char_valid || (reg_sel && reg_write && test_access_mode))
		&& $past(char_available_flag))
		else $error("overrun without cause");
	ovr_empty_a: assert property (rx_s ##0 !char_available_flag |=> !overrun_pulse)
		else $error("overrun on empty buffer");
	ovr_single_a: assert property (rx_s ##0 !fifo_enable && char_available_flag && !reg_sel |=> overrun_pulse)
		else $error("overwrite not flagged");
	inj_direct_a: assert property (rd_s(RX_INJECT_OFS) or (test_access_mode && !fifo_enable && reg_sel && reg_write && reg_addr == RX_INJECT_OFS) |=> char_available_flag || reg_rdata == 0)
		else $error("inject did not load buffer");
	alias_pop_a: assert property (alias_rd_s ##0 !fifo_enable && !rx_char_valid |=> !char_available_flag)
		else $error("alias read did not consume");
endmodule
`default_nettype wire

// >>> bench/usb_host_model.sv
// Host model driving the register port of the alias block.
// Assumes requests launch at the falling edge; answer one edge later.
`timescale 1ns/1ps
`default_nettype none
module usb_host_model (
	// Clock
	input  wire logic        core_clk,
	// Register port
	output logic             reg_sel,
	output logic             reg_write,
	output logic [7:0]       reg_addr,
	output logic [31:0]      reg_wdata,
	input  wire logic [31:0] reg_rdata
);
	// Idle port from time zero
	initial begin
		reg_sel = 1'b0;
		reg_write = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0000_0000;
	end
	// One strobe for one edge, answer taken a cycle later, data then inverted
	task automatic access(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(negedge core_clk);
		reg_sel = 1'b1;
		reg_write = wr;
		reg_addr = a;
		reg_wdata = d;
		@(negedge core_clk);
		reg_sel = 1'b0;
		reg_wdata = ~d;
		q = reg_rdata;
	endtask
endmodule
`default_nettype wire

// >>> bench/test_uart_shadow_buffer_fifo_test_access.sv
// Self-checking bench for the alias block with a host model.
// Assumes usb_top, usb_host_model and usb_checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_uart_shadow_buffer_fifo_test_access;
	import usb_pkg::*;
	// Stimulus and observation
	logic        core_clk = 1'b0, rst = 1'b1, fifo_enable = 1'b0, rx_char_valid = 1'b0;
	logic        rx_framing_err = 1'b0, rx_parity_err = 1'b0, tx_char_ready = 1'b0;
	logic        reg_sel, reg_write, tx_char_valid, char_available_flag, overrun_pulse;
	logic        rx_head_framing_err, rx_head_parity_err, test_access_mode;
	logic [7:0]  reg_addr, rx_char = 8'h00, tx_char;
	logic [31:0] reg_wdata, reg_rdata, q, seed = 32'h0000_108f;
	logic [9:0]  b [0:4];
	int          mismatches = 0, tests_run = 0;
	always #12.5 core_clk = ~core_clk;
	usb_top u_dut (.core_clk, .rst, .reg_sel, .reg_write, .reg_addr, .reg_wdata, .reg_rdata,
		.fifo_enable, .rx_char_valid, .rx_char, .rx_framing_err, .rx_parity_err,
		.tx_char_valid, .tx_char, .tx_char_ready, .char_available_flag, .overrun_pulse,
		.rx_head_framing_err, .rx_head_parity_err, .test_access_mode);
	usb_host_model u_host (.core_clk, .reg_sel, .reg_write, .reg_addr, .reg_wdata, .reg_rdata);
	////////////////////////////////////////////////////////////////////////
	// Random source and expected alias word
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [31:0] word(input logic [7:0] c);
		return {24'h00_0000, c};
	endfunction
	// Compare and count
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Register accesses and one received character
	task automatic rd(input logic [7:0] a);
		u_host.access(1'b0, a, 32'h0000_0000, q);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		u_host.access(1'b1, a, d, q);
	endtask
	task automatic rx(input logic [7:0] c);
		@(negedge core_clk);
		rx_char_valid = 1'b1;
		rx_char = c;
		@(negedge core_clk);
		rx_char_valid = 1'b0;
		rx_char = ~c;
	endtask
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	// Hang guard
	initial begin
		repeat (5000) @(posedge core_clk);
		mismatches++;
		print_verdict();
	end
	// Main sequence
	initial begin
		repeat (3) @(negedge core_clk);
		rst = 1'b0;
		rd(TEST_EN_OFS);
		check(q, 32'h0000_0000);
		// FIFO mode: fill, fifth arrival is dropped, drain across the alias range
		fifo_enable = 1'b1;
		for (int i = 0; i < 5; i++) begin
			seed = lfsr(seed);
			b[i] = seed[9:0];
			rx(b[i][7:0]);
			check(overrun_pulse, i == 4);
		end
		for (int i = 0; i < 4; i++) begin
			check(char_available_flag, 1'b1);
			rd(i == 3 ? ALIAS_HI_OFS : ALIAS_LO_OFS + 8'(12 * i));
			check(q, word(b[i][7:0]));
		end
		check(char_available_flag, 1'b0);
		// Single buffer: second arrival overwrites the first
		fifo_enable = 1'b0;
		rx(8'h5a);
		check(overrun_pulse, 1'b0);
		rx(8'ha5);
		check(overrun_pulse, 1'b1);
		rd(ALIAS_LO_OFS + 8'h04);
		check(q, word(8'ha5));
		// Transmit alias writes, transmitter stalled, then peeked in test mode
		fifo_enable = 1'b1;
		for (int i = 0; i < 3; i++) begin
			seed = lfsr(seed);
			b[i] = seed[9:0];
			wr(ALIAS_LO_OFS + 8'(8 * i), seed);
		end
		check({tx_char_valid, tx_char}, {1'b1, b[0][7:0]});
		rd(TX_PEEK_OFS);
		check(q, 32'h0000_0000);
		wr(TEST_EN_OFS, 32'h0000_0001);
		rd(TEST_EN_OFS);
		check(q, 32'h0000_0001);
		for (int i = 0; i < 3; i++) begin
			rd(TX_PEEK_OFS);
			check(q, word(b[i][7:0]));
		end
		// Inject into the receive FIFO with random error flags
		for (int i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			b[i] = seed[9:0];
			wr(RX_INJECT_OFS, seed);
		end
		for (int i = 0; i < 4; i++) begin
			// Head flags are registered one cycle after a pop
			@(negedge core_clk);
			check({rx_head_framing_err, rx_head_parity_err}, b[i][9:8]);
			rd(ALIAS_LO_OFS);
			check(q, word(b[i][7:0]));
		end
		// Inject straight into the single buffer
		fifo_enable = 1'b0;
		wr(RX_INJECT_OFS, 32'h0000_03c3);
		check({char_available_flag, rx_head_framing_err, rx_head_parity_err}, 3'h7);
		rd(ALIAS_LO_OFS);
		check(q, word(8'hc3));
		// Test mode off: inject ignored, unmapped read is zero
		wr(TEST_EN_OFS, 32'h0000_0000);
		wr(RX_INJECT_OFS, 32'h0000_0011);
		check(char_available_flag, 1'b0);
		rd(8'h7c);
		check(q, 32'h0000_0000);
		print_verdict();
	end
endmodule
bind usb_top usb_checker u_chk (.core_clk, .rst, .reg_sel, .reg_write, .reg_addr, .reg_rdata,
	.fifo_enable, .rx_char_valid, .char_available_flag, .overrun_pulse, .test_access_mode);
`default_nettype wire
